// ===== pkg/fidc_pkg.sv
// Package for the flash front-end host controller: pin timing, command codes, operation codes.
// Assumes a 40 MHz mclk and a parallel flash with separate data in/out/enable pins.
package fidc_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int GLITCH_NS = 5;
	// Strobe low time held well above the glitch filter width
	localparam int STROBE_NS = 50;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_NS = 100;
	localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_NS = 500;
	localparam int RESET_CYC = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] UNLOCK1_WORD = 20'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK2_WORD = 20'h002aa;
	localparam logic [ADDR_W-1:0] UNLOCK1_BYTE = 20'h00aaa;
	localparam logic [ADDR_W-1:0] UNLOCK2_BYTE = 20'h00555;
	localparam logic [7:0] UNLOCK1_DATA = 8'haa;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [ADDR_W-1:0] ID_MAKER_OFS = 20'h00000;
	localparam logic [ADDR_W-1:0] ID_PART_WORD_OFS = 20'h00001;
	localparam logic [ADDR_W-1:0] ID_PART_BYTE_OFS = 20'h00002;
	localparam logic [ADDR_W-1:0] ID_PROT_OFS = 20'h00002;
	localparam logic [ADDR_W-1:0] ID_CONT_OFS = 20'h00003;
	localparam int SECTOR_LSB_WORD = 12;
	localparam logic [7:0] PROT_YES = 8'h01;
	localparam logic [7:0] PROT_NO = 8'h00;
	localparam int TIMING_LIMIT_BIT = 5;
	typedef enum logic [2:0] {
		FIDC_OP_READ,
		FIDC_OP_PROGRAM,
		FIDC_OP_CHIP_ERASE,
		FIDC_OP_SECTOR_ERASE,
		FIDC_OP_IDENT,
		FIDC_OP_RESET,
		FIDC_OP_SUSPEND,
		FIDC_OP_RESUME
	} fidc_op_t;
endpackage

// ===== verilog/fidc_host.sv
// Host controller that drives a parallel boot-sector flash through its strobes and buses.
// Assumes flash pins are synchronous to mclk; data pin tri-state resolved outside.
//
// Functional notes
// - Byte mode adds address bit below zero
// - Elevated-voltage identifier needs nine high, pattern
// - Identifier mode also reachable by command sequence
// - Program and erase need unlock sequence
// - Write needs select, write low, output-enable high
// - Reset command regains array reads
`timescale 1ns/1ps
module fidc_host
	import fidc_pkg::*;
#(
	parameter int RESET_CYCLES = fidc_pkg::RESET_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// User request
	input wire logic req_valid,
	input wire fidc_pkg::fidc_op_t req_op,
	input wire logic [fidc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [fidc_pkg::DATA_W-1:0] req_data,
	input wire logic byte_mode,
	input wire logic hw_reset_req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [fidc_pkg::DATA_W-1:0] rsp_data,
	output logic rsp_timing_limit,
	// Flash pins
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic flash_reset_n,
	output logic flash_byte_n,
	output logic [fidc_pkg::ADDR_W-1:0] flash_addr,
	output logic [fidc_pkg::DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [fidc_pkg::DATA_W-1:0] flash_dq_i
);
	import fidc_pkg::*;

	typedef enum logic [2:0] {
		FIDC_IDLE, FIDC_PIN_RESET, FIDC_W_SETUP, FIDC_W_PULSE, FIDC_W_HOLD,
		FIDC_R_PULSE, FIDC_R_DONE
	} fidc_state_t;

	fidc_state_t state_ff;
	logic [2:0] cyc_idx_ff;
	logic [2:0] cyc_last_ff;
	logic [15:0] tmr_ff;
	fidc_op_t op_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] data_ff;
	logic byte_ff;
	logic [ADDR_W-1:0] nxt_addr;
	logic [DATA_W-1:0] nxt_data;

	// Unlock cycle address in the current width mode
	function automatic logic [ADDR_W-1:0] unlock_addr(input logic second, input logic bm);
		if (bm) begin
			return second ? UNLOCK2_BYTE : UNLOCK1_BYTE;
		end
		return second ? UNLOCK2_WORD : UNLOCK1_WORD;
	endfunction

	// Number of bus write cycles for each operation other than a read, minus one
	function automatic logic [2:0] op_last(input fidc_op_t op);
		case (op)
			FIDC_OP_PROGRAM: op_last = 3'h3;
			FIDC_OP_CHIP_ERASE, FIDC_OP_SECTOR_ERASE: op_last = 3'h5;
			FIDC_OP_IDENT: op_last = 3'h2;
			default: op_last = 3'h0;
		endcase
	endfunction

	// Address and data of write cycle idx of the current command sequence
	always_comb begin
		nxt_addr = unlock_addr(1'b0, byte_ff);
		nxt_data = {8'h00, UNLOCK1_DATA};
		case (cyc_idx_ff)
			3'h1, 3'h4: begin
				nxt_addr = unlock_addr(1'b1, byte_ff);
				nxt_data = {8'h00, UNLOCK2_DATA};
			end
			3'h0: begin
				if (op_ff == FIDC_OP_RESET || op_ff == FIDC_OP_SUSPEND || op_ff == FIDC_OP_RESUME) begin
					nxt_addr = addr_ff;
					nxt_data = {8'h00, (op_ff == FIDC_OP_RESET) ? CMD_RESET :
						(op_ff == FIDC_OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME};
				end
			end
			3'h2: begin
				nxt_data = {8'h00, (op_ff == FIDC_OP_PROGRAM) ? CMD_PROGRAM :
					(op_ff == FIDC_OP_IDENT) ? CMD_IDENT : CMD_ERASE_SETUP};
			end
			3'h3: begin
				if (op_ff == FIDC_OP_PROGRAM) begin
					nxt_addr = addr_ff;
					nxt_data = data_ff;
				end
			end
			3'h5: begin
				if (op_ff == FIDC_OP_SECTOR_ERASE) begin
					nxt_addr = addr_ff;
					nxt_data = {8'h00, CMD_SECTOR_ERASE};
				end else begin
					nxt_data = {8'h00, CMD_CHIP_ERASE};
				end
			end
			default: begin
				nxt_addr = addr_ff;
				nxt_data = data_ff;
			end
		endcase
	end

	// Sequencer; each strobe phase is held for a whole count so no glitch is seen
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= FIDC_PIN_RESET;
			tmr_ff <= 16'h0000;
			cyc_idx_ff <= 3'h0;
			cyc_last_ff <= 3'h0;
			op_ff <= FIDC_OP_READ;
			addr_ff <= '0;
			data_ff <= '0;
			byte_ff <= 1'b0;
		end else begin
			case (state_ff)
				FIDC_IDLE: begin
					if (hw_reset_req) begin
						state_ff <= FIDC_PIN_RESET;
						tmr_ff <= 16'h0000;
					end else if (req_valid) begin
						op_ff <= req_op;
						addr_ff <= req_addr;
						data_ff <= req_data;
						byte_ff <= byte_mode;
						cyc_idx_ff <= 3'h0;
						cyc_last_ff <= op_last(req_op);
						tmr_ff <= 16'h0000;
						state_ff <= (req_op == FIDC_OP_READ) ? FIDC_R_PULSE : FIDC_W_SETUP;
					end
				end
				FIDC_PIN_RESET: begin
					tmr_ff <= tmr_ff + 16'h0001;
					if (tmr_ff >= 16'(RESET_CYCLES - 1)) begin
						state_ff <= FIDC_IDLE;
					end
				end
				FIDC_W_SETUP: begin
					state_ff <= FIDC_W_PULSE;
					tmr_ff <= 16'h0000;
				end
				FIDC_W_PULSE: begin
					tmr_ff <= tmr_ff + 16'h0001;
					if (tmr_ff >= 16'(STROBE_CYC - 1)) begin
						state_ff <= FIDC_W_HOLD;
						tmr_ff <= 16'h0000;
					end
				end
				FIDC_W_HOLD: begin
					tmr_ff <= tmr_ff + 16'h0001;
					if (tmr_ff >= 16'(STROBE_CYC - 1)) begin
						tmr_ff <= 16'h0000;
						if (cyc_idx_ff == cyc_last_ff) begin
							state_ff <= FIDC_IDLE;
						end else begin
							cyc_idx_ff <= cyc_idx_ff + 3'h1;
							state_ff <= FIDC_W_SETUP;
						end
					end
				end
				FIDC_R_PULSE: begin
					tmr_ff <= tmr_ff + 16'h0001;
					if (tmr_ff >= 16'(READ_CYC - 1)) begin
						state_ff <= FIDC_R_DONE;
					end
				end
				FIDC_R_DONE: state_ff <= FIDC_IDLE;
				default: state_ff <= FIDC_IDLE;
			endcase
		end
	end

	// Flash pin drive; write address is set before chip-select and write fall, read address on the same edge as select
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_reset_n <= 1'b0;
			flash_byte_n <= 1'b1;
			flash_addr <= '0;
			flash_dq_o <= '0;
			flash_dq_oe <= 1'b0;
		end else begin
			flash_reset_n <= (state_ff != FIDC_PIN_RESET);
			flash_byte_n <= ~byte_ff;
			case (state_ff)
				FIDC_W_SETUP: begin
					flash_addr <= nxt_addr;
					flash_dq_o <= nxt_data;
					flash_dq_oe <= 1'b1;
					flash_oe_n <= 1'b1;
					flash_ce_n <= 1'b1;
					flash_we_n <= 1'b1;
				end
				FIDC_W_PULSE: begin
					flash_ce_n <= 1'b0;
					flash_we_n <= 1'b0;
				end
				FIDC_W_HOLD: begin
					// Write strobe rises first so data is taken on its edge; select follows a cycle later
					flash_we_n <= 1'b1;
					flash_ce_n <= (tmr_ff != 16'h0000);
				end
				FIDC_R_PULSE: begin
					flash_addr <= addr_ff;
					flash_dq_oe <= 1'b0;
					flash_we_n <= 1'b1;
					flash_ce_n <= 1'b0;
					flash_oe_n <= 1'b0;
				end
				default: begin
					flash_ce_n <= 1'b1;
					flash_oe_n <= 1'b1;
					flash_we_n <= 1'b1;
					flash_dq_oe <= 1'b0;
				end
			endcase
		end
	end

	// User handshake and read capture; array, identifier or status data alike
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rsp_timing_limit <= 1'b0;
		end else begin
			req_ready <= (state_ff == FIDC_IDLE) && !req_valid && !hw_reset_req;
			rsp_valid <= 1'b0;
			if (state_ff == FIDC_R_PULSE && tmr_ff >= 16'(READ_CYC - 1)) begin
				rsp_valid <= 1'b1;
				rsp_data <= byte_ff ? {8'h00, flash_dq_i[7:0]} : flash_dq_i;
				rsp_timing_limit <= flash_dq_i[TIMING_LIMIT_BIT];
			end
		end
	end
endmodule

// ===== testbench/fidc_host_chk.sv
// Checker for the flash host controller pins and response pulse.
// Assumes binding into fidc_host; everything sampled on mclk.
`timescale 1ns/1ps
module fidc_host_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Flash side
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic flash_reset_n,
	input wire logic flash_dq_oe,
	input wire logic [19:0] flash_addr,
	input wire logic [15:0] flash_dq_o,
	// Response
	input wire logic rsp_valid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// One write: strobe low two cycles, select released one cycle after it
	sequence s_wr_strobe;
		!flash_we_n ##1 !flash_we_n ##1 flash_we_n && !flash_ce_n ##1 flash_ce_n;
	endsequence
	AST_WE_PULSE: assert property ($fell(flash_we_n) |-> s_wr_strobe)
		else $error("write strobe shape wrong");
	AST_WR_QUAL: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n)
		else $error("write without select or with output enable");
	AST_WR_HOLD: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_o) && flash_dq_oe)
		else $error("address or data moved under write strobe");
	AST_RD_NO_DRIVE: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
		else $error("host drives data during read");
	AST_RD_ANSWER: assert property ($fell(flash_oe_n) |-> ##[1:6] rsp_valid)
		else $error("read not answered");
	AST_RSP_ONE: assert property (rsp_valid |=> !rsp_valid)
		else $error("response pulse too long");
	AST_RST_QUIET: assert property (!flash_reset_n |-> flash_we_n && flash_ce_n && flash_oe_n)
		else $error("strobes active while flash held in reset");
	AST_RST_WIDTH: assert property ($fell(flash_reset_n) |-> !flash_reset_n[*2])
		else $error("flash reset pulse too short");
	AST_RST_PINS: assert property (disable iff (1'b0) rst |-> !flash_reset_n && flash_we_n && !flash_dq_oe)
		else $error("pins not quiet during reset");
endmodule

bind fidc_host fidc_host_chk u_chk (.mclk, .rst, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
	.flash_dq_oe, .flash_addr, .flash_dq_o, .rsp_valid);

// ===== testbench/fidc_flash_model.sv
// Behavioural parallel flash: array, unlock decoder, identifier mode.
// Assumes word-mode command addresses; no sector is protected.
`timescale 1ns/1ps
module fidc_flash_model #(
	parameter logic [15:0] MAKER = 16'h004a, // Arbitrary value
	parameter logic [15:0] PART = 16'h2251, // Arbitrary value
	parameter logic [15:0] CONT = 16'h006d // Arbitrary value
) (
	// Strobes
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic byte_n,
	// Buses
	input wire logic [19:0] addr,
	input wire logic [15:0] dq_o,
	output logic [15:0] dq_i
);
	import fidc_pkg::*;
	logic [15:0] mem [logic [19:0]];
	logic [19:0] la, wa;
	logic [15:0] w, rd;
	logic [7:0] d;
	logic [2:0] step;
	logic ident, arm, live;
	time tf;
	int nwr;
	initial begin
		step = 0;
		ident = 0;
		arm = 0;
		live = 0;
		tf = 0;
		nwr = 0;
	end
	assign d = dq_o[7:0];
	assign wa = byte_n ? addr : {1'b0, addr[19:1]};
	// Re-evaluated on every array change as well as on address moves
	always @(wa or addr or byte_n or ident or nwr) begin
		w = mem.exists(wa) ? mem[wa] : ~wa[15:0];
		if (ident)
			w = addr[1:0] == 2'h0 ? MAKER : addr[1:0] == 2'h1 ? PART : addr[1:0] == 2'h3 ? CONT : 16'h0000;
		rd = byte_n ? w : {8'h00, addr[0] ? w[15:8] : w[7:0]};
	end
	// Released bus shows the inverse, never a stale value
	assign dq_i = (!ce_n && !oe_n && reset_n) ? rd : ~rd;
	always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
		la = addr;
		tf = $time;
		live = 1;
	end
	always @(posedge we_n or posedge ce_n or negedge reset_n) begin
		if (!reset_n) begin
			step = 0;
			ident = 0;
			arm = 0;
		end else if (live && oe_n && $time - tf >= 5 && (ce_n ^ we_n)) begin
			if (arm) begin
				mem[la] = dq_o;
				arm = 0;
				nwr++;
			end else if (d == CMD_RESET) begin
				step = 0;
				ident = 0;
			end else if (step == 0 && la == UNLOCK1_WORD && d == UNLOCK1_DATA) step = 1;
			else if (step == 1 && la == UNLOCK2_WORD && d == UNLOCK2_DATA) step = 2;
			else if (step == 2 && d == CMD_IDENT) begin
				ident = 1;
				step = 0;
			end else if (step == 2 && d == CMD_PROGRAM) begin
				arm = 1;
				step = 0;
			end else if (step == 2 && d == CMD_ERASE_SETUP) step = 3;
			else if (step == 3 && la == UNLOCK1_WORD && d == UNLOCK1_DATA) step = 4;
			else if (step == 4 && la == UNLOCK2_WORD && d == UNLOCK2_DATA) step = 5;
			else if (step == 5 && (d == CMD_CHIP_ERASE || d == CMD_SECTOR_ERASE)) begin
				foreach (mem[k]) begin
					if (d == CMD_CHIP_ERASE || k[19:SECTOR_LSB_WORD] == la[19:SECTOR_LSB_WORD]) mem[k] = 16'hffff;
				end
				nwr++;
				step = 0;
			end else step = 0;
		end
	end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the flash host controller against a flash model.
// Assumes fidc_host ports as declared and a short flash reset pulse.
`timescale 1ns/1ps
module testbench;
	import fidc_pkg::*;
	typedef struct {fidc_op_t o; logic [19:0] a; logic [15:0] d; logic [15:0] e;} fidc_row_t;
	logic mclk, rst, req_valid, byte_mode, hw_reset_req, req_ready, rsp_valid, rsp_timing_limit;
	logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_byte_n, flash_dq_oe;
	fidc_op_t req_op;
	logic [19:0] req_addr, flash_addr;
	logic [15:0] req_data, rsp_data, flash_dq_o, flash_dq_i;
	int error_cnt, n_checks, cyc;
	fidc_row_t rows [19] = '{
		'{FIDC_OP_READ, 20'h00100, 16'h0000, 16'hfeff},
		'{FIDC_OP_PROGRAM, 20'h00100, 16'h1234, 16'h0000},
		'{FIDC_OP_READ, 20'h00100, 16'h0000, 16'h1234},
		'{FIDC_OP_IDENT, 20'h00000, 16'h0000, 16'h0000},
		'{FIDC_OP_READ, 20'h00000, 16'h0000, 16'h004a},
		'{FIDC_OP_READ, 20'h00003, 16'h0000, 16'h006d},
		'{FIDC_OP_READ, 20'h00001, 16'h0000, 16'h2251},
		'{FIDC_OP_READ, 20'h01002, 16'h0000, 16'h0000},
		'{FIDC_OP_RESET, 20'h00000, 16'h0000, 16'h0000},
		'{FIDC_OP_READ, 20'h00100, 16'h0000, 16'h1234},
		'{FIDC_OP_SUSPEND, 20'h00000, 16'h0000, 16'h0000},
		'{FIDC_OP_RESUME, 20'h00000, 16'h0000, 16'h0000},
		'{FIDC_OP_PROGRAM, 20'h08000, 16'h5678, 16'h0000},
		'{FIDC_OP_SECTOR_ERASE, 20'h00000, 16'h0000, 16'h0000},
		'{FIDC_OP_READ, 20'h00100, 16'h0000, 16'hffff},
		'{FIDC_OP_READ, 20'h08000, 16'h0000, 16'h5678},
		'{FIDC_OP_CHIP_ERASE, 20'h00000, 16'h0000, 16'h0000},
		'{FIDC_OP_READ, 20'h08000, 16'h0000, 16'hffff},
		'{FIDC_OP_PROGRAM, 20'h00100, 16'h1234, 16'h0000}};
	fidc_host #(.RESET_CYCLES(2)) dut (.mclk, .rst, .req_valid, .req_op, .req_addr, .req_data, .byte_mode,
		.hw_reset_req, .req_ready, .rsp_valid, .rsp_data, .rsp_timing_limit, .flash_ce_n, .flash_oe_n,
		.flash_we_n, .flash_reset_n, .flash_byte_n, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i);
	fidc_flash_model mdl (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n),
		.byte_n(flash_byte_n), .addr(flash_addr), .dq_o(flash_dq_o), .dq_i(flash_dq_i));
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic tally_and_finish;
		if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Waits for idle, issues one request, checks read data
	task automatic run_op(fidc_row_t r);
		int n;
		n = 0;
		@(negedge mclk);
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		if (req_ready !== 1'b1) begin
			$display("[FAIL] req_ready exp 1 got %b", req_ready);
			error_cnt++;
		end
		@(posedge mclk);
		req_valid <= 1;
		req_op <= r.o;
		req_addr <= r.a;
		req_data <= r.d;
		@(posedge mclk);
		req_valid <= 0;
		if (r.o == FIDC_OP_READ) begin
			n = 0;
			@(negedge mclk);
			while (rsp_valid !== 1'b1 && n < 20) begin
				@(negedge mclk);
				n++;
			end
			n_checks++;
			if (rsp_valid !== 1'b1) begin
				$display("[FAIL] rsp_valid at %h exp 1 got %b", r.a, rsp_valid);
				error_cnt++;
			end
			if (rsp_data !== r.e) begin
				$display("[FAIL] rsp_data at %h exp %h got %h", r.a, r.e, rsp_data);
				error_cnt++;
			end
			if (rsp_timing_limit !== r.e[TIMING_LIMIT_BIT]) begin
				$display("[FAIL] rsp_timing_limit at %h exp %b got %b", r.a, r.e[TIMING_LIMIT_BIT], rsp_timing_limit);
				error_cnt++;
			end
		end
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	initial begin
		rst = 1'b1;
		{req_valid, byte_mode, hw_reset_req} = 3'h0;
		req_addr = 20'h00000;
		req_data = 16'h0000;
		req_op = FIDC_OP_READ;
		repeat (10) @(posedge mclk);
		rst <= 0;
		foreach (rows[i]) run_op(rows[i]);
		run_op(rows[3]);
		@(posedge mclk);
		hw_reset_req <= 1;
		// Held until the controller reaches idle and pulls the flash reset pin
		do begin
			@(posedge mclk);
		end while (flash_reset_n !== 1'b0);
		hw_reset_req <= 0;
		run_op('{FIDC_OP_READ, 20'h00000, 16'h0000, 16'hffff});
		@(posedge mclk);
		byte_mode <= 1;
		run_op('{FIDC_OP_READ, 20'h00201, 16'h0000, 16'h0012});
		tally_and_finish;
	end
endmodule
